//--- design/pcm_pkg.sv
package pcm_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int CSS_TIMEOUT_NS  = 2000;
    localparam int CSS_TIMEOUT_CYC = (CSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSS_CNT_W       = 12;
    localparam logic [CSS_CNT_W-1:0] CSS_LAST = CSS_CNT_W'(CSS_TIMEOUT_CYC - 1);

    // Register byte offsets
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_MODE    = 5'h04;
    localparam logic [4:0] OFS_STATUS  = 5'h08;
    localparam logic [4:0] OFS_IRQ_EN  = 5'h0C;
    localparam logic [4:0] OFS_IRQ_CLR = 5'h10;
    localparam logic [4:0] OFS_INFO    = 5'h14;

    // Control word field positions
    localparam int CTRL_CLK_SEL = 0;
    localparam int CTRL_EXT_EN  = 2;
    localparam int CTRL_PLL_EN  = 3;
    localparam int CTRL_CSS_EN  = 4;
    localparam int CTRL_PVD_EN  = 5;
    localparam int CTRL_PVD_DN  = 6;
    localparam int CTRL_PVD_UP  = 7;
    localparam int CTRL_STOP_LP = 8;

    // Interrupt bits
    localparam int IRQ_CSS = 0;
    localparam int IRQ_PLL = 1;
    localparam int IRQ_PVD = 2;
    localparam int IRQ_W   = 3;

    // Clock sources and boot sources
    localparam logic [1:0] CLK_RC      = 2'h0;
    localparam logic [1:0] CLK_EXT     = 2'h1;
    localparam logic [1:0] CLK_PLL     = 2'h2;
    localparam logic [1:0] BOOT_FLASH  = 2'h0;
    localparam logic [1:0] BOOT_SYSMEM = 2'h1;
    localparam logic [1:0] BOOT_SRAM   = 2'h2;

    // Mode request codes written to the mode register
    localparam logic [1:0] REQ_SLEEP = 2'h1;
    localparam logic [1:0] REQ_STOP  = 2'h2;
    localparam logic [1:0] REQ_STBY  = 2'h3;

    // Index of each asynchronous input in the synchroniser vector
    localparam int AI_EXT_TGL = 0;
    localparam int AI_PLL     = 1;
    localparam int AI_PVD     = 2;
    localparam int AI_SUPPLY  = 3;
    localparam int AI_RST_N   = 4;
    localparam int AI_WAKEUP_PIN    = 5;
    localparam int AI_RTC     = 6;
    localparam int AI_USB     = 7;
    localparam int AI_INDEPENDENT_WATCHDOG    = 8;
    localparam int AI_BOOT0   = 9;
    localparam int AI_BOOT1   = 10;
    localparam int AI_W       = 11;
    localparam int NUM_LINES  = 16;
    localparam logic [AI_W-1:0] SYNC_RST = 11'h010;

    typedef enum logic [3:0] {
        PCM_RUN   = 4'h1,
        PCM_SLEEP = 4'h2,
        PCM_STOP  = 4'h4,
        PCM_STBY  = 4'h8
    } pcm_mode_t;

    typedef struct packed {
        pcm_mode_t            mode;
        logic [1:0]           clk_sel;
        logic                 ext_en;
        logic                 pll_en;
        logic                 css_en;
        logic                 pvd_en;
        logic                 pvd_dn;
        logic                 pvd_up;
        logic                 stop_lp;
        logic [IRQ_W-1:0]     irq_st;
        logic [IRQ_W-1:0]     irq_en;
        logic [1:0]           boot;
        logic                 boot_done;
        logic [CSS_CNT_W-1:0] css_cnt;
    } pcm_ctl_t;

    typedef struct packed {
        pcm_ctl_t             c;
        logic [AI_W-1:0]      sync1;
        logic [AI_W-1:0]      sync2;
        logic [AI_W-1:0]      prev;
        logic [NUM_LINES-1:0] lsync1;
        logic [NUM_LINES-1:0] lsync2;
        logic                 ack;
        logic [31:0]          rdata;
    } pcm_state_t;

    localparam pcm_ctl_t CTL_RST = '{mode: PCM_RUN, clk_sel: CLK_RC, boot: BOOT_FLASH, default: '0};
    localparam pcm_state_t PCM_RST = '{c: CTL_RST, sync1: SYNC_RST, sync2: SYNC_RST, prev: SYNC_RST,
                                       default: '0};
endpackage

//--- design/pcm_power_clock_ctrl.sv
`timescale 1ns/1ps
module pcm_power_clock_ctrl (
    input  wire logic                          I_CORE_CLK,
    input  wire logic                          I_RESETN,
    input  wire logic [4:0]                    I_AVS_ADDRESS,
    input  wire logic                          I_AVS_READ,
    input  wire logic                          I_AVS_WRITE,
    input  wire logic [31:0]                   I_AVS_WRITEDATA,
    input  wire logic [3:0]                    I_AVS_BYTEENABLE,
    output logic      [31:0]                   O_AVS_READDATA,
    output logic                               O_AVS_WAITREQUEST,
    input  wire logic                          I_EXT_OSC_TOGGLE,
    input  wire logic                          I_PLL_LOCK,
    input  wire logic                          I_PVD_BELOW,
    input  wire logic                          I_SUPPLY_LOW,
    input  wire logic                          I_EXT_RESET_PIN_N,
    input  wire logic                          I_WAKEUP_PIN,
    input  wire logic                          I_RTC_ALARM,
    input  wire logic                          I_USB_WAKEUP,
    input  wire logic                          I_WATCHDOG_RESET,
    input  wire logic [1:0]                    I_BOOT_PINS,
    input  wire logic [pcm_pkg::NUM_LINES-1:0] I_EVENT_LINES,
    input  wire logic                          I_CORE_EVENT,
    output logic                               O_IRQ,
    output logic      [1:0]                    O_CLK_SEL,
    output logic                               O_CPU_CLK_EN,
    output logic                               O_PERIPH_CLK_EN,
    output logic                               O_RC_OSC_EN,
    output logic                               O_EXT_OSC_EN,
    output logic                               O_PLL_EN,
    output logic                               O_PVD_EN,
    output logic                               O_REG_MAIN,
    output logic                               O_REG_LOW_POWER,
    output logic                               O_REG_HIZ,
    output logic                               O_CORE_PWR_EN,
    output logic                               O_CORE_RESET_N,
    output logic      [1:0]                    O_BOOT_SRC,
    output logic                               O_BACKUP_DOMAIN_EN
);
    pcm_pkg::pcm_state_t s;
    pcm_pkg::pcm_state_t next_s;

    logic [pcm_pkg::AI_W-1:0] async_in;
    logic                     req;
    logic                     run_like;
    logic                     in_stby;
    logic                     int_rst;
    logic                     ext_tick;
    logic                     pll_lost;
    logic                     pvd_rise;
    logic                     pvd_fall;
    logic                     wakeup_pin_rise;
    logic                     stop_wake;
    logic                     css_active;
    logic                     css_fail;
    logic                     irq_any;

    // Local constants; IRQ_W_T sizes the interrupt next-state variables below, CSS_ONE steps the timeout counter
    localparam int IRQ_W_T = pcm_pkg::IRQ_W;
    localparam logic [pcm_pkg::CSS_CNT_W-1:0] CSS_ONE = 12'h001;

    // Merge a bus write into an old word, lane by lane
    function automatic logic [31:0] pcm_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // Control fields as they appear in the control word
    function automatic logic [31:0] pcm_ctrl_word(input pcm_pkg::pcm_ctl_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pcm_pkg::CTRL_CLK_SEL +: 2] = c.clk_sel;
        w[pcm_pkg::CTRL_EXT_EN]       = c.ext_en;
        w[pcm_pkg::CTRL_PLL_EN]       = c.pll_en;
        w[pcm_pkg::CTRL_CSS_EN]       = c.css_en;
        w[pcm_pkg::CTRL_PVD_EN]       = c.pvd_en;
        w[pcm_pkg::CTRL_PVD_DN]       = c.pvd_dn;
        w[pcm_pkg::CTRL_PVD_UP]       = c.pvd_up;
        w[pcm_pkg::CTRL_STOP_LP]      = c.stop_lp;
        return w;
    endfunction

    // Read mux; unmapped and write-only offsets read as zero
    function automatic logic [31:0] pcm_read(input pcm_pkg::pcm_state_t st, input logic [4:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == pcm_pkg::OFS_CTRL) begin
            r = pcm_ctrl_word(st.c);
        end else if (a == pcm_pkg::OFS_STATUS) begin
            r[pcm_pkg::IRQ_W-1:0] = st.c.irq_st;
        end else if (a == pcm_pkg::OFS_IRQ_EN) begin
            r[pcm_pkg::IRQ_W-1:0] = st.c.irq_en;
        end else if (a == pcm_pkg::OFS_INFO) begin
            r[3:0] = st.c.mode;
            r[5:4] = st.c.clk_sel;
            r[7:6] = st.c.boot;
            r[8]   = st.sync2[pcm_pkg::AI_PVD];
            r[9]   = st.sync2[pcm_pkg::AI_PLL];
        end
        return r;
    endfunction

    // Asynchronous inputs gathered for the two-stage synchroniser
    assign async_in = {I_BOOT_PINS[1], I_BOOT_PINS[0], I_WATCHDOG_RESET, I_USB_WAKEUP, I_RTC_ALARM,
                       I_WAKEUP_PIN, I_EXT_RESET_PIN_N, I_SUPPLY_LOW, I_PVD_BELOW, I_PLL_LOCK,
                       I_EXT_OSC_TOGGLE};

    // Events decoded from the second synchroniser stage only
    assign req        = I_AVS_READ | I_AVS_WRITE;
    assign run_like   = (s.c.mode == pcm_pkg::PCM_RUN) || (s.c.mode == pcm_pkg::PCM_SLEEP);
    assign in_stby    = (s.c.mode == pcm_pkg::PCM_STBY);
    assign ext_tick   = s.sync2[pcm_pkg::AI_EXT_TGL] ^ s.prev[pcm_pkg::AI_EXT_TGL];
    assign pll_lost   = s.c.pll_en & s.prev[pcm_pkg::AI_PLL] & ~s.sync2[pcm_pkg::AI_PLL];
    assign pvd_rise   = s.sync2[pcm_pkg::AI_PVD] & ~s.prev[pcm_pkg::AI_PVD];
    assign pvd_fall   = ~s.sync2[pcm_pkg::AI_PVD] & s.prev[pcm_pkg::AI_PVD];
    assign wakeup_pin_rise  = s.sync2[pcm_pkg::AI_WAKEUP_PIN] & ~s.prev[pcm_pkg::AI_WAKEUP_PIN];
    assign stop_wake  = (|s.lsync2) | s.sync2[pcm_pkg::AI_PVD] | s.sync2[pcm_pkg::AI_RTC]
                      | s.sync2[pcm_pkg::AI_USB];
    assign css_active = s.c.css_en & s.c.ext_en & (s.c.clk_sel != pcm_pkg::CLK_RC) & run_like;
    assign css_fail   = css_active & ~ext_tick & (s.c.css_cnt == pcm_pkg::CSS_LAST);
    assign irq_any    = |(s.c.irq_st & s.c.irq_en);

    // Device-level reset causes; standby wake goes through the same path
    assign int_rst = ~s.sync2[pcm_pkg::AI_RST_N] | s.sync2[pcm_pkg::AI_SUPPLY]
                   | s.sync2[pcm_pkg::AI_INDEPENDENT_WATCHDOG]
                   | (in_stby & (wakeup_pin_rise | s.sync2[pcm_pkg::AI_RTC]));

    // Next-state logic for the whole block
    always_comb begin
        logic [31:0]          wd;
        logic [IRQ_W_T-1:0]   irq_set;
        logic [IRQ_W_T-1:0]   irq_clr;
        logic [31:0]          cw;
        wd      = I_AVS_WRITEDATA;
        irq_set = '0;
        irq_clr = '0;
        cw      = 32'h0000_0000;
        next_s  = s;
        next_s.sync1  = async_in;
        next_s.sync2  = s.sync1;
        next_s.prev   = s.sync2;
        next_s.lsync1 = I_EVENT_LINES;
        next_s.lsync2 = s.lsync1;

        // Bus slave: one wait state, read data captured on the first cycle
        if (req && !s.ack) begin
            next_s.ack   = 1'b1;
            next_s.rdata = pcm_read(s, I_AVS_ADDRESS);
        end else begin
            next_s.ack = 1'b0;
        end

        if (I_AVS_WRITE && s.ack) begin
            if (I_AVS_ADDRESS == pcm_pkg::OFS_CTRL) begin
                cw = pcm_merge(pcm_ctrl_word(s.c), wd, I_AVS_BYTEENABLE);
                next_s.c.clk_sel = cw[pcm_pkg::CTRL_CLK_SEL +: 2];
                next_s.c.ext_en  = cw[pcm_pkg::CTRL_EXT_EN];
                next_s.c.pll_en  = cw[pcm_pkg::CTRL_PLL_EN];
                next_s.c.css_en  = cw[pcm_pkg::CTRL_CSS_EN];
                next_s.c.pvd_en  = cw[pcm_pkg::CTRL_PVD_EN];
                next_s.c.pvd_dn  = cw[pcm_pkg::CTRL_PVD_DN];
                next_s.c.pvd_up  = cw[pcm_pkg::CTRL_PVD_UP];
                next_s.c.stop_lp = cw[pcm_pkg::CTRL_STOP_LP];
            end else if (I_AVS_ADDRESS == pcm_pkg::OFS_MODE) begin
                if (I_AVS_BYTEENABLE[0] && s.c.mode == pcm_pkg::PCM_RUN) begin
                    case (wd[1:0])
                        pcm_pkg::REQ_SLEEP: begin
                            next_s.c.mode = pcm_pkg::PCM_SLEEP;
                        end
                        pcm_pkg::REQ_STOP: begin
                            // Oscillators are re-armed by software after wake
                            next_s.c.mode    = pcm_pkg::PCM_STOP;
                            next_s.c.ext_en  = 1'b0;
                            next_s.c.pll_en  = 1'b0;
                            next_s.c.clk_sel = pcm_pkg::CLK_RC;
                        end
                        pcm_pkg::REQ_STBY: begin
                            next_s.c.mode = pcm_pkg::PCM_STBY;
                        end
                        default: begin
                            next_s.c.mode = s.c.mode;
                        end
                    endcase
                end
            end else if (I_AVS_ADDRESS == pcm_pkg::OFS_IRQ_EN) begin
                cw = pcm_merge({29'h0, s.c.irq_en}, wd, I_AVS_BYTEENABLE);
                next_s.c.irq_en = cw[pcm_pkg::IRQ_W-1:0];
            end else if (I_AVS_ADDRESS == pcm_pkg::OFS_IRQ_CLR) begin
                irq_clr = wd[pcm_pkg::IRQ_W-1:0] & {pcm_pkg::IRQ_W{I_AVS_BYTEENABLE[0]}};
            end
        end

        // Wake from Sleep on any enabled interrupt or event, from Stop on event lines, PVD, RTC or USB wakeup
        if (s.c.mode == pcm_pkg::PCM_SLEEP && (I_CORE_EVENT || irq_any || stop_wake)) begin
            next_s.c.mode = pcm_pkg::PCM_RUN;
        end else if (s.c.mode == pcm_pkg::PCM_STOP && stop_wake) begin
            next_s.c.mode = pcm_pkg::PCM_RUN;
        end

        // Clock security: the external clock must toggle within the timeout
        if (css_active && !ext_tick) begin
            next_s.c.css_cnt = s.c.css_cnt + CSS_ONE;
        end else begin
            next_s.c.css_cnt = '0;
        end
        if (css_fail) begin
            next_s.c.clk_sel = pcm_pkg::CLK_RC;
            next_s.c.ext_en  = 1'b0;
            next_s.c.css_cnt = '0;
            irq_set[pcm_pkg::IRQ_CSS] = 1'b1;
        end

        // Losing the PLL input flags software and drops back to RC when the PLL is the selected clock
        if (pll_lost) begin
            irq_set[pcm_pkg::IRQ_PLL] = 1'b1;
            if (s.c.clk_sel == pcm_pkg::CLK_PLL) begin
                next_s.c.clk_sel = pcm_pkg::CLK_RC;
            end
        end

        // Supply detector edges, each direction enabled on its own
        if (s.c.pvd_en && ((pvd_rise && s.c.pvd_dn) || (pvd_fall && s.c.pvd_up))) begin
            irq_set[pcm_pkg::IRQ_PVD] = 1'b1;
        end

        // A set arriving with a clear is kept
        next_s.c.irq_st = (s.c.irq_st & ~irq_clr) | irq_set;

        // Boot pins are caught once per reset, after the release
        if (!s.c.boot_done) begin
            next_s.c.boot_done = 1'b1;
            if (!s.sync2[pcm_pkg::AI_BOOT0]) begin
                next_s.c.boot = pcm_pkg::BOOT_FLASH;
            end else if (!s.sync2[pcm_pkg::AI_BOOT1]) begin
                next_s.c.boot = pcm_pkg::BOOT_SYSMEM;
            end else begin
                next_s.c.boot = pcm_pkg::BOOT_SRAM;
            end
        end

        // Device reset clears control state but keeps synchronisers and bus
        if (int_rst) begin
            next_s.c = pcm_pkg::CTL_RST;
        end
    end

    // State register; the synchronisers keep shifting through reset so that the
    // boot pins and reset causes are already valid at the first edge after release
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESETN) begin
            s        <= pcm_pkg::PCM_RST;
            s.sync1  <= next_s.sync1;
            s.sync2  <= next_s.sync2;
            s.prev   <= next_s.prev;
            s.lsync1 <= next_s.lsync1;
            s.lsync2 <= next_s.lsync2;
        end else begin
            s <= next_s;
        end
    end

    // Bus answer: waitrequest is combinational, data from flops
    assign O_AVS_WAITREQUEST = req & ~s.ack;
    assign O_AVS_READDATA    = s.rdata;

    // Interrupt, clock and power controls decoded from the mode and control flops
    assign O_IRQ              = irq_any;
    assign O_CLK_SEL          = s.c.clk_sel;
    assign O_CPU_CLK_EN       = (s.c.mode == pcm_pkg::PCM_RUN);
    assign O_PERIPH_CLK_EN    = run_like;
    assign O_RC_OSC_EN        = run_like;
    assign O_EXT_OSC_EN       = run_like & s.c.ext_en;
    assign O_PLL_EN           = run_like & s.c.pll_en;
    assign O_PVD_EN           = s.c.pvd_en;
    assign O_REG_MAIN         = run_like | ((s.c.mode == pcm_pkg::PCM_STOP) & ~s.c.stop_lp);
    assign O_REG_LOW_POWER    = (s.c.mode == pcm_pkg::PCM_STOP) & s.c.stop_lp;
    assign O_REG_HIZ          = in_stby;
    assign O_CORE_PWR_EN      = ~in_stby;
    assign O_CORE_RESET_N     = s.c.boot_done;
    assign O_BOOT_SRC         = s.c.boot;
    // Low-speed domain never gated: RTC and watchdog outlive every mode
    assign O_BACKUP_DOMAIN_EN = 1'b1;

    // Checks on the controller
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);

    a_reset_to_rc: assert property (int_rst |=> O_CLK_SEL == pcm_pkg::CLK_RC && !O_CORE_RESET_N)
        else $error("reset did not select RC clock");
    a_css_fallback: assert property (css_fail && !int_rst |=> O_CLK_SEL == pcm_pkg::CLK_RC)
        else $error("clock failure did not fall back to RC");
    a_css_irq_gate: assert property (css_fail && !int_rst && s.c.irq_en[pcm_pkg::IRQ_CSS] |=> O_IRQ)
        else $error("enabled clock failure gave no interrupt");
    a_pll_loss: assert property (pll_lost && !int_rst |=> s.c.irq_st[pcm_pkg::IRQ_PLL])
        else $error("PLL loss not flagged");
    a_boot_stable: assert property (O_CORE_RESET_N && !int_rst |=> $stable(O_BOOT_SRC))
        else $error("boot source changed outside reset");
    a_supply_hold: assert property (s.sync2[pcm_pkg::AI_SUPPLY] |=> !O_CORE_RESET_N)
        else $error("core left reset while supply low");
    a_pvd_edge: assert property (s.c.pvd_en && s.c.pvd_dn && pvd_rise && !int_rst
                                 |=> s.c.irq_st[pcm_pkg::IRQ_PVD])
        else $error("supply drop not flagged");
    a_pvd_off: assert property (!s.c.pvd_en |=> !$rose(s.c.irq_st[pcm_pkg::IRQ_PVD]))
        else $error("supply detector active while off");
    a_hiz_only_stby: assert property (O_REG_HIZ |-> s.c.mode == pcm_pkg::PCM_STBY && !O_CORE_PWR_EN)
        else $error("regulator off outside standby");
    a_sleep_clocks: assert property (s.c.mode == pcm_pkg::PCM_SLEEP |-> !O_CPU_CLK_EN && O_PERIPH_CLK_EN)
        else $error("sleep clock gating wrong");
    a_stop_osc_off: assert property ($rose(s.c.mode == pcm_pkg::PCM_STOP) |-> !O_PLL_EN && !O_EXT_OSC_EN
                                     && !O_RC_OSC_EN)
        else $error("oscillators left on in stop");
    a_stop_wake: assert property (s.c.mode == pcm_pkg::PCM_STOP && stop_wake |=> s.c.mode == pcm_pkg::PCM_RUN)
        else $error("stop did not wake on event");
    a_stby_hold: assert property (in_stby && !int_rst |=> in_stby)
        else $error("standby left without a wake source");
    a_bus_answer: assert property (req && !s.ack |=> !O_AVS_WAITREQUEST || !req)
        else $error("bus answer late");

    // Boot source must follow the pins as seen one edge before the core is released
    a_boot_decode: assert property ($rose(O_CORE_RESET_N) |-> O_BOOT_SRC == (!$past(s.sync2[pcm_pkg::AI_BOOT0])
                                    ? pcm_pkg::BOOT_FLASH : (!$past(s.sync2[pcm_pkg::AI_BOOT1])
                                    ? pcm_pkg::BOOT_SYSMEM : pcm_pkg::BOOT_SRAM)))
        else $error("boot source does not match pins");
    a_reg_after_rst: assert property (!O_CORE_RESET_N && !in_stby |-> O_REG_MAIN && !O_REG_HIZ)
        else $error("regulator not in main mode during reset");
    a_pvd_reset_off: assert property (!O_CORE_RESET_N |-> !O_PVD_EN)
        else $error("supply detector on during reset");
    a_stop_reg_sel: assert property (s.c.mode == pcm_pkg::PCM_STOP
                                     |-> O_REG_LOW_POWER == s.c.stop_lp && O_REG_MAIN == !s.c.stop_lp)
        else $error("stop regulator mode not as configured");
    a_stop_clk_off: assert property (s.c.mode == pcm_pkg::PCM_STOP |-> !O_CPU_CLK_EN && !O_PERIPH_CLK_EN)
        else $error("core clocks running in stop");
    a_stby_power: assert property (in_stby |-> !O_PLL_EN && !O_EXT_OSC_EN && !O_RC_OSC_EN && !O_REG_MAIN)
        else $error("standby left power or oscillators on");
    a_stby_wake: assert property (in_stby && wakeup_pin_rise |=> !in_stby && !O_CORE_RESET_N)
        else $error("standby ignored wakeup pin");
    a_backup_on: assert property (O_BACKUP_DOMAIN_EN)
        else $error("backup domain gated");
    a_irq_masked: assert property (!(|(s.c.irq_st & s.c.irq_en)) |-> !O_IRQ)
        else $error("interrupt without enabled status");

    c_sleep_wake: cover property (s.c.mode == pcm_pkg::PCM_SLEEP ##1 s.c.mode == pcm_pkg::PCM_RUN);
    c_stop_wake: cover property (s.c.mode == pcm_pkg::PCM_STOP ##1 s.c.mode == pcm_pkg::PCM_RUN);
    c_css_fail: cover property (css_fail);
    c_stby_exit: cover property (in_stby && int_rst ##1 !O_CORE_RESET_N ##1 O_CORE_RESET_N);
    // Supply detector interrupt taken on a threshold crossing in either enabled direction
    c_pvd_irq: cover property ($rose(s.c.irq_st[pcm_pkg::IRQ_PVD]));
endmodule

//--- testbench/pcm_osc_model.sv
`timescale 1ns/1ps
// Stand-in for the external oscillator; a dead crystal leaves its line frozen
module pcm_osc_model (
    input  wire logic i_clk,
    input  wire logic i_en,
    input  wire logic i_alive,
    output logic      o_toggle
);
    initial o_toggle = 1'b0;
    // Toggles only while enabled and healthy, so a fault shows as silence
    always @(posedge i_clk) begin
        if (i_en && i_alive) begin
            o_toggle <= ~o_toggle;
        end
    end
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} pcm_row_t;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] q;
    logic [9:0]  pin = 10'h209; // PLL locked, reset pin high, oscillator alive
    logic [15:0] lines = 16'h0;
    logic [1:0]  boot = 2'h0;
    wire  [31:0] rdata;
    wire         wreq;
    wire         tgl;
    wire         ext_en;
    wire  [1:0]  csel;
    wire  [9:0]  st;
    wire  [1:0]  bsrc;
    int          fails = 0;
    int          samples_checked = 0;
    pcm_row_t    rows [7] = '{'{0, 5'h14, 0, 32'h201}, '{0, 5'h00, 0, 0}, '{0, 5'h08, 0, 0}, '{0, 5'h18, 0, 0},
                              '{1, 5'h00, 32'hF5, 0}, '{0, 5'h00, 0, 32'hF5}, '{0, 5'h14, 0, 32'h211}};
    initial begin
        forever #10 clk = ~clk;
    end
    pcm_osc_model osc (.i_clk(clk), .i_en(ext_en), .i_alive(pin[9]), .o_toggle(tgl));
    pcm_power_clock_ctrl dut (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wreq), .I_EXT_OSC_TOGGLE(tgl), .I_PLL_LOCK(pin[0]), .I_PVD_BELOW(pin[1]),
        .I_SUPPLY_LOW(pin[2]), .I_EXT_RESET_PIN_N(pin[3]), .I_WAKEUP_PIN(pin[4]), .I_RTC_ALARM(pin[5]),
        .I_USB_WAKEUP(pin[6]), .I_WATCHDOG_RESET(pin[7]), .I_BOOT_PINS(boot), .I_EVENT_LINES(lines),
        .I_CORE_EVENT(pin[8]), .O_IRQ(st[9]), .O_CLK_SEL(csel), .O_CPU_CLK_EN(st[8]),
        .O_PERIPH_CLK_EN(st[7]), .O_RC_OSC_EN(), .O_EXT_OSC_EN(ext_en), .O_PLL_EN(st[1]), .O_PVD_EN(),
        .O_REG_MAIN(st[6]), .O_REG_LOW_POWER(st[5]), .O_REG_HIZ(st[4]), .O_CORE_PWR_EN(st[3]),
        .O_CORE_RESET_N(st[2]), .O_BOOT_SRC(bsrc), .O_BACKUP_DOMAIN_EN());
    assign st[0] = ext_en;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(negedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        if (n >= 50) fails++;
        q = rdata;
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Let edges pass, then look where outputs are settled
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Bounded against a hang; tests take well under a thousand cycles
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wt(1);
        chk("run", 10'h1CC, st);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("reg", rows[i].e, q);
        end
        chk("clksel", 2'h1, csel);
        @(posedge clk) pin[9] <= 1'b0;
        wt(130);
        chk("fallback", 2'h0, csel);
        chk("masked", 10'h1CC, st);
        bus(0, 5'h08, 0);
        chk("status", 32'h1, q);
        bus(1, 5'h0C, 32'h5);
        wt(2);
        chk("irq", 1'b1, st[9]);
        bus(1, 5'h10, 32'h1);
        bus(1, 5'h00, 32'h16C);
        @(posedge clk) pin[0] <= 1'b0;
        wt(4);
        bus(0, 5'h08, 0);
        chk("pll", 32'h2, q);
        @(posedge clk) pin[0] <= 1'b1;
        bus(1, 5'h10, 32'h2);
        @(posedge clk) pin[1] <= 1'b1;
        wt(4);
        chk("pvd", 10'h3CF, st);
        @(posedge clk) pin[1] <= 1'b0;
        bus(1, 5'h10, 32'h4);
        bus(1, 5'h02, 0);
        bus(1, 5'h04, 32'h2);
        wt(2);
        chk("stop", 10'h02C, st);
        @(posedge clk) lines[3] <= 1'b1;
        wt(4);
        chk("stopwake", 10'h1CC, st);
        @(posedge clk) lines <= 16'h0;
        bus(1, 5'h04, 32'h1);
        wt(2);
        chk("sleep", 10'h0CC, st);
        @(posedge clk) pin[8] <= 1'b1;
        @(posedge clk) pin[8] <= 1'b0;
        wt(2);
        chk("sleepwake", 10'h1CC, st);
        @(posedge clk) boot <= 2'h3;
        bus(1, 5'h04, 32'h3);
        wt(2);
        chk("stby", 2'h2, st[4:3]);
        @(posedge clk) pin[4] <= 1'b1;
        wt(10);
        chk("stbywake", 10'h1CC, st);
        bus(0, 5'h14, 0);
        chk("reboot", 32'h281, q);
        chk("bootsrc", 2'h2, bsrc);
        @(posedge clk) pin[2] <= 1'b1;
        wt(4);
        chk("por", 1'b0, st[2]);
        print_verdict();
    end
endmodule
